// [design/adcl_pkg.sv]
// shared constants and the ns_to_cyc helper for the converter readout link
// Summary of operation
// R1 - result bit appears on each serial clock rise
// R2 - host waits for line low before clocking
// R3 - 24-bit result shifted out MSB first
// R4 - unread result overwritten after one period
// R5 - host avoids clocking during update window
// R6 - after 24 clocks line holds last bit
// R7 - 25th clock rise forces line high
// R8 - period 12.5 ms fast, 100 ms slow
// R9 - host holds clock high to request standby
// R10 - host raises clock soon after ready falls
// R11 - standby after clock high one full period
// R12 - line stays high during standby
// R13 - clock low ends standby, first result valid
// R14 - first ready 52.6 or 401.8 ms after wakeup
// R15 - power-down pin low resets all logic
// R16 - 7.95 us wakeup after power-down release
// R17 - rate pin high 80 SPS, low 10 SPS
// R18 - bridge switch closed converting, open otherwise
// R19 - result is clipped 24-bit two's complement
package adcl_pkg;
	localparam int CLK_NS = 50;
	localparam real T_CONV_FAST_MS = 12.5;
	localparam real T_CONV_SLOW_MS = 100.0;
	localparam real T_UPD_US = 90.0;
	localparam real T_SRDY_FAST_MS = 52.6;
	localparam real T_SRDY_SLOW_MS = 401.8;
	localparam real T_WAKE_US = 7.95;
	localparam real T_POWER_OFF_N_US = 26.0;
	localparam real T_SCLK_HALF_NS = 400.0;

	function automatic int ns_to_cyc(input real t_ns);
		return $rtoi(t_ns / CLK_NS + 0.5);
	endfunction

	localparam int CONV_FAST_CYC = ns_to_cyc(T_CONV_FAST_MS * 1.0e6);
	localparam int CONV_SLOW_CYC = ns_to_cyc(T_CONV_SLOW_MS * 1.0e6);
	localparam int UPD_CYC = ns_to_cyc(T_UPD_US * 1.0e3);
	localparam int SRDY_FAST_CYC = ns_to_cyc(T_SRDY_FAST_MS * 1.0e6);
	localparam int SRDY_SLOW_CYC = ns_to_cyc(T_SRDY_SLOW_MS * 1.0e6);
	localparam int WAKE_CYC = ns_to_cyc(T_WAKE_US * 1.0e3);
	localparam int POWER_OFF_N_CYC = ns_to_cyc(T_POWER_OFF_N_US * 1.0e3);
	localparam int SCLK_HALF_CYC = ns_to_cyc(T_SCLK_HALF_NS);

	localparam int RES_BITS = 24;
	localparam int CNT_W = 24;
	localparam logic [23:0] FULL_POS = 24'h7FFFFF;
	localparam logic [23:0] FULL_NEG = 24'h800000;
	localparam logic [4:0] LAST_BIT = 5'h18;
	localparam int FIFO_DEPTH = 4;
endpackage

// [design/adcl_link_if.sv]
// pin bundle between the converter end and the host end
`timescale 1ns/1ps
`default_nettype none
interface adcl_link_if;
	logic sclk;
	logic power_off_n;
	logic ready_and_result_line;
	logic bridge_low_switch;
	modport dev (input sclk, input power_off_n, output ready_and_result_line, output bridge_low_switch);
	modport host (output sclk, output power_off_n, input ready_and_result_line, input bridge_low_switch);
endinterface
`default_nettype wire

// [design/adcl_fifo.sv]
// small valid/ready fifo for result words
`timescale 1ns/1ps
`default_nettype none
module adcl_fifo #(
	parameter int W = 24,
	parameter int D = 4
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} adcl_fifo_t;
	adcl_fifo_t s_q, s_d;
	logic full, empty;

	always_comb begin
		empty = (s_q.wp == s_q.rp);
		full = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
		in_ready = !full;
		out_valid = !empty;
		out_data = s_q.mem[s_q.rp[AW-1:0]];
		s_d = s_q;
		if (in_valid && !full) begin
			s_d.mem[s_q.wp[AW-1:0]] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// [design/adcl_dev.sv]
// converter end: conversion timing, serial readout, standby and power-down
`timescale 1ns/1ps
`default_nettype none
module adcl_dev #(
	parameter int unsigned CONV_FAST = adcl_pkg::CONV_FAST_CYC,
	parameter int unsigned CONV_SLOW = adcl_pkg::CONV_SLOW_CYC,
	parameter int unsigned UPD = adcl_pkg::UPD_CYC,
	parameter int unsigned SRDY_FAST = adcl_pkg::SRDY_FAST_CYC,
	parameter int unsigned SRDY_SLOW = adcl_pkg::SRDY_SLOW_CYC,
	parameter int unsigned WAKE = adcl_pkg::WAKE_CYC
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	adcl_link_if.dev         link,
	input  wire logic        rate_fast,
	input  wire logic [24:0] conv_value,
	output logic             conv_ready,
	output logic             in_standby
);
	localparam int CW = adcl_pkg::CNT_W;

	typedef enum logic [2:0] {
		D_OFF    = 3'b000,
		D_WAKE   = 3'b001,
		D_CONV   = 3'b010,
		D_STBY   = 3'b011,
		D_RESUME = 3'b100
	} adcl_dev_st_t;

	typedef struct packed {
		adcl_dev_st_t  st;
		logic [CW-1:0] cnt;
		logic [CW-1:0] hi_cnt;
		logic [23:0]   shreg;
		logic [4:0]    nbit;
		logic          line;
		logic          sw;
		logic          rdy;
		logic          stby;
		logic [1:0]    sclk_s;
		logic [1:0]    pd_s;
		logic [1:0]    spd_s;
		logic          sclk_p;
	} adcl_dev_t;

	adcl_dev_t s_q, s_d;
	logic          sclk_rise;
	logic [CW-1:0] period;
	logic [CW-1:0] srdy;

	function automatic logic [23:0] clip24(input logic [24:0] v);
		if (!v[24] && v[23]) begin
			return adcl_pkg::FULL_POS;
		end else if (v[24] && !v[23]) begin
			return adcl_pkg::FULL_NEG;
		end
		return v[23:0];
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.sclk_s = {s_q.sclk_s[0], link.sclk};
		s_d.pd_s = {s_q.pd_s[0], link.power_off_n};
		s_d.spd_s = {s_q.spd_s[0], rate_fast};
		s_d.sclk_p = s_q.sclk_s[1];
		s_d.rdy = 1'b0;
		sclk_rise = s_q.sclk_s[1] && !s_q.sclk_p;
		// R8 R17 rate pin picks the period
		period = s_q.spd_s[1] ? CW'(CONV_FAST) : CW'(CONV_SLOW);
		srdy = s_q.spd_s[1] ? CW'(SRDY_FAST) : CW'(SRDY_SLOW);
		case (s_q.st)
			D_OFF: begin
				s_d.cnt = '0;
				if (s_q.pd_s[1]) begin
					s_d.st = D_WAKE;
				end
			end
			D_WAKE: begin
				// R16 wakeup delay before converting
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= CW'(WAKE - 1)) begin
					s_d.st = D_CONV;
					s_d.cnt = '0;
					s_d.sw = 1'b1;
				end
			end
			D_CONV: begin
				s_d.cnt = s_q.cnt + 1'b1;
				s_d.hi_cnt = s_q.sclk_s[1] ? s_q.hi_cnt + 1'b1 : '0;
				if (sclk_rise && s_q.cnt < period - CW'(UPD)) begin
					if (s_q.nbit < adcl_pkg::LAST_BIT) begin
						// R1 R3 next bit, MSB first
						s_d.line = s_q.shreg[23];
						s_d.shreg = {s_q.shreg[22:0], 1'b0};
						s_d.nbit = s_q.nbit + 1'b1;
					end else begin
						// R7 extra clock forces the line high
						s_d.line = 1'b1;
					end
				end
				// R6 R4 update window raises the line and discards unread bits
				if (s_q.cnt == period - CW'(UPD)) begin
					s_d.line = 1'b1;
				end
				if (s_q.cnt >= period - 1'b1) begin
					// R19 clipped result loaded, ready shown low
					s_d.cnt = '0;
					s_d.shreg = clip24(conv_value);
					s_d.nbit = '0;
					s_d.line = 1'b0;
					s_d.rdy = 1'b1;
				end
				// R11 clock held high a full period enters standby
				if (s_q.sclk_s[1] && s_q.hi_cnt >= period - 1'b1) begin
					s_d.st = D_STBY;
					s_d.line = 1'b1;
					s_d.sw = 1'b0;
					s_d.stby = 1'b1;
					s_d.rdy = 1'b0;
				end
			end
			D_STBY: begin
				// R12 line stays high; R13 clock low wakes
				s_d.line = 1'b1;
				if (!s_q.sclk_s[1]) begin
					s_d.st = D_RESUME;
					s_d.cnt = '0;
					s_d.hi_cnt = '0;
					s_d.sw = 1'b1;
					s_d.stby = 1'b0;
				end
			end
			D_RESUME: begin
				// R14 first result after the resume delay
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= srdy - 1'b1) begin
					s_d.st = D_CONV;
					s_d.cnt = '0;
					s_d.shreg = clip24(conv_value);
					s_d.nbit = '0;
					s_d.line = 1'b0;
					s_d.rdy = 1'b1;
				end
			end
			default: begin
				s_d.st = D_OFF;
			end
		endcase
		// R15 power-down resets everything, R18 switch opens
		if (!s_q.pd_s[1]) begin
			s_d.st = D_OFF;
			s_d.cnt = '0;
			s_d.hi_cnt = '0;
			s_d.shreg = '0;
			s_d.nbit = '0;
			s_d.line = 1'b1;
			s_d.sw = 1'b0;
			s_d.rdy = 1'b0;
			s_d.stby = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: D_OFF, line: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.ready_and_result_line = s_q.line;
	assign link.bridge_low_switch = s_q.sw;
	assign conv_ready = s_q.rdy;
	assign in_standby = s_q.stby;
endmodule
`default_nettype wire

// [design/adcl_host.sv]
// host end: polls ready, clocks out results, requests standby and power-down
`timescale 1ns/1ps
`default_nettype none
module adcl_host #(
	parameter int unsigned HALF = adcl_pkg::SCLK_HALF_CYC,
	parameter int unsigned POWER_OFF_N = adcl_pkg::POWER_OFF_N_CYC,
	parameter int DEPTH = adcl_pkg::FIFO_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	adcl_link_if.host        link,
	input  wire logic        standby_req,
	input  wire logic        power_down_req,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [23:0]      rd_data
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_HIGH = 3'b001,
		H_LOW  = 3'b010,
		H_PUSH = 3'b011,
		H_STBY = 3'b100
	} adcl_host_st_t;

	typedef struct packed {
		adcl_host_st_t st;
		logic [9:0]    ph;
		logic [4:0]    nbit;
		logic [23:0]   shreg;
		logic          sclk;
		logic          pdn;
		logic [9:0]    pcnt;
		logic [1:0]    line_s;
	} adcl_host_t;

	adcl_host_t s_q, s_d;
	logic       push;
	logic       push_ready;
	logic       line;

	always_comb begin
		s_d = s_q;
		s_d.line_s = {s_q.line_s[0], link.ready_and_result_line};
		line = s_q.line_s[1];
		push = (s_q.st == H_PUSH);
		case (s_q.st)
			H_IDLE: begin
				// R2 wait for ready low; R9 R10 standby raised at once
				if (!line) begin
					s_d.st = standby_req ? H_STBY : H_HIGH;
					s_d.sclk = 1'b1;
					s_d.ph = '0;
					s_d.nbit = '0;
				end
			end
			H_HIGH: begin
				s_d.ph = s_q.ph + 1'b1;
				if (s_q.ph >= 10'(HALF - 1)) begin
					s_d.st = H_LOW;
					s_d.sclk = 1'b0;
					s_d.ph = '0;
				end
			end
			H_LOW: begin
				s_d.ph = s_q.ph + 1'b1;
				if (s_q.ph >= 10'(HALF - 1)) begin
					s_d.ph = '0;
					s_d.nbit = s_q.nbit + 1'b1;
					if (s_q.nbit < adcl_pkg::LAST_BIT) begin
						s_d.shreg = {s_q.shreg[22:0], line};
					end
					// R7 done after the extra clock
					if (s_q.nbit == adcl_pkg::LAST_BIT) begin
						s_d.st = H_PUSH;
					end else begin
						s_d.st = standby_req ? H_STBY : H_HIGH;
						s_d.sclk = 1'b1;
					end
				end
			end
			H_PUSH: begin
				if (push_ready) begin
					s_d.st = H_IDLE;
				end
			end
			H_STBY: begin
				// R12 clock kept high; R13 dropping it wakes the converter
				if (!standby_req) begin
					s_d.st = H_IDLE;
					s_d.sclk = 1'b0;
				end
			end
			default: begin
				s_d.st = H_IDLE;
			end
		endcase
		// R15 power-down pulse held at least its least width
		if (s_q.pdn && power_down_req) begin
			s_d.pdn = 1'b0;
			s_d.pcnt = '0;
		end else if (!s_q.pdn) begin
			if (s_q.pcnt < 10'(POWER_OFF_N - 1)) begin
				s_d.pcnt = s_q.pcnt + 1'b1;
			end else if (!power_down_req) begin
				s_d.pdn = 1'b1;
			end
		end
		if (!s_q.pdn) begin
			s_d.st = H_IDLE;
			s_d.sclk = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: H_IDLE, pdn: 1'b1, line_s: 2'h3, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.sclk = s_q.sclk;
	assign link.power_off_n = s_q.pdn;

	adcl_fifo #(
		.W (adcl_pkg::RES_BITS),
		.D (DEPTH)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (s_q.shreg),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);
endmodule
`default_nettype wire

// [dv/adcl_sva.sv]
// link checker for the converter readout interface
`timescale 1ns/1ps
`default_nettype none
module adcl_sva #(
	parameter int CONV = 700
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic power_off_n,
	input wire logic ready_and_result_line,
	input wire logic bridge_low_switch
);
	localparam int W_MAX = 1100;
	logic [4:0]  nr_q;
	logic [15:0] hi_q;
	logic [10:0] wt_q;
	logic        wt_on_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// rises since result load, sclk high time
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nr_q <= 5'h00;
			hi_q <= 16'h0000;
			wt_q <= 11'h000;
			wt_on_q <= 1'b0;
		end else begin
			hi_q <= sclk ? hi_q + 16'h0001 : 16'h0000;
			// cycles from switch closing until the first ready
			if ($rose(bridge_low_switch)) begin
				wt_on_q <= 1'b1;
				wt_q <= 11'h000;
			end else if (!ready_and_result_line || !bridge_low_switch) begin
				wt_on_q <= 1'b0;
			end else if (wt_on_q && wt_q != 11'h7FF) begin
				wt_q <= wt_q + 11'h001;
			end
			if (!power_off_n || ($fell(ready_and_result_line) && !sclk))
				nr_q <= 5'h00;
			else if ($rose(sclk) && nr_q != 5'h1F)
				nr_q <= nr_q + 5'h01;
		end
	end
	AST_FORCE_HIGH: assert property (
		$rose(sclk) && nr_q == 5'h18 |-> ##[3:4] ready_and_result_line) else $error("no forced high");
	AST_WAIT_READY: assert property (
		$rose(sclk) && nr_q == 5'h00 |-> !ready_and_result_line) else $error("clock before ready");
	AST_LOW_STABLE: assert property (
		nr_q inside {[1:24]} && !sclk && $past(!sclk) && !$fell(ready_and_result_line)
		|-> $stable(ready_and_result_line))
		else $error("line moved in low phase");
	AST_OFF_IDLE: assert property (
		!power_off_n [*4] |-> ready_and_result_line && !bridge_low_switch) else $error("not off");
	AST_OPEN_HIGH: assert property (
		!bridge_low_switch |-> ready_and_result_line) else $error("line low while idle");
	AST_STBY_LATE: assert property (
		$fell(bridge_low_switch) && power_off_n && $past(power_off_n, 4) |-> hi_q >= CONV)
		else $error("standby too early");
	AST_WAKE_END: assert property (
		$fell(sclk) && !bridge_low_switch && power_off_n |-> ##[3:5] bridge_low_switch)
		else $error("standby not left");
	AST_WAKE_READY: assert property (
		$rose(bridge_low_switch) |-> ready_and_result_line [*8])
		else $error("ready too soon after wake");
	AST_WAKE_LIMIT: assert property (
		wt_on_q |-> wt_q < W_MAX)
		else $error("no first result");
	AST_PD_WAKE: assert property (
		$rose(power_off_n) |-> !bridge_low_switch [*8] ##[1:8] bridge_low_switch)
		else $error("bad wake time");
	cover property ($rose(sclk) && nr_q == 5'h18);
	cover property ($fell(bridge_low_switch) && power_off_n);
	cover property ($rose(power_off_n));
endmodule
`default_nettype wire

// [dv/testbench.sv]
// top bench for the converter readout link
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int CF = 700;
	localparam int CS = 1000;
	localparam int SF = 900;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        rate_fast = 1'b1;
	logic [24:0] conv_value = 25'h0000000;
	logic        standby_req = 1'b0;
	logic        power_down_req = 1'b0;
	logic        rd_ready = 1'b1;
	logic        conv_ready;
	logic        in_standby;
	logic        rd_valid;
	logic [23:0] rd_data;
	int          fails = 0;
	int          num_checks = 0;
	int          n;
	logic [24:0] tbl [5] = '{25'h0000001, 25'h0FFFFFF, 25'h1000000, 25'h1FFFFFF, 25'h05A5A5A};
	adcl_link_if lk ();
	adcl_dev #(.CONV_FAST(CF), .CONV_SLOW(CS), .UPD(40), .SRDY_FAST(SF), .SRDY_SLOW(1050), .WAKE(8)) u_adcl_dev (
		.clock(clock), .nrst(nrst), .link(lk), .rate_fast(rate_fast), .conv_value(conv_value),
		.conv_ready(conv_ready), .in_standby(in_standby));
	adcl_host #(.POWER_OFF_N(8)) u_adcl_host (.clock(clock), .nrst(nrst), .link(lk), .standby_req(standby_req),
		.power_down_req(power_down_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	adcl_sva #(.CONV(CF)) u_adcl_sva (.clock(clock), .nrst(nrst), .sclk(lk.sclk), .power_off_n(lk.power_off_n),
		.ready_and_result_line(lk.ready_and_result_line), .bridge_low_switch(lk.bridge_low_switch));
	always #25 clock = ~clock;
	function automatic logic [23:0] clip(input logic [24:0] v);
		if ($signed(v) > 25'sh07FFFFF)
			return 24'h7FFFFF;
		if ($signed(v) < -25'sh0800000)
			return 24'h800000;
		return v[23:0];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	// waits at falling edges, cycle count left in n
	task automatic waitf(ref logic s, input int lim);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (s !== 1'b1 && n < lim);
		if (n >= lim)
			check(32'h0, 32'h1);
	endtask
	task automatic t_fifo();
		waitf(conv_ready, 2000);
		conv_value = tbl[0];
		repeat (500) @(negedge clock);
		rd_ready = 1'b0;
		for (int k = 1; k <= 5; k++) begin
			waitf(conv_ready, 2000);
			if (k < 5)
				conv_value = tbl[k];
		end
		repeat (450) @(negedge clock);
		for (int k = 0; k < 5; k++) begin
			waitf(rd_valid, 20);
			check(rd_data, clip(tbl[k]));
			rd_ready = 1'b1;
			@(negedge clock);
			rd_ready = 1'b0;
		end
		check(rd_valid, 1'b0);
		rd_ready = 1'b1;
	endtask
	task automatic t_rate();
		for (int i = 0; i < 2; i++) begin
			rate_fast = i[0];
			waitf(conv_ready, 2000);
			waitf(conv_ready, 2000);
			waitf(conv_ready, 2000);
			check(n, i ? CF : CS);
		end
	endtask
	task automatic t_stby();
		conv_value = 25'h0123456;
		standby_req = 1'b1;
		waitf(in_standby, 2000);
		repeat (50) @(negedge clock);
		check({in_standby, lk.ready_and_result_line, lk.bridge_low_switch}, 3'h6);
		standby_req = 1'b0;
		waitf(conv_ready, SF + 20);
		check(n >= SF && n <= SF + 10, 1'b1);
		waitf(rd_valid, 600);
		check(rd_data, 24'h123456);
	endtask
	task automatic t_pd();
		conv_value = 25'h1ABCDEF;
		waitf(conv_ready, 1200);
		repeat (100) @(negedge clock);
		power_down_req = 1'b1;
		@(negedge clock);
		power_down_req = 1'b0;
		repeat (6) @(negedge clock);
		check({lk.ready_and_result_line, lk.bridge_low_switch}, 2'h2);
		waitf(rd_valid, 2000);
		check(rd_data, 24'hABCDEF);
	endtask
	task automatic test_done();
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clock);
		check({lk.ready_and_result_line, lk.bridge_low_switch, in_standby, rd_valid}, 4'h8);
		nrst = 1'b1;
		t_fifo();
		t_rate();
		t_stby();
		t_pd();
		test_done();
	end
	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
